// File: core/mtap_fsm.sv
`timescale 1ns/100ps
`default_nettype none
module mtap_fsm (
  input  wire logic          tck,         // Test clock
  input  wire logic          rst,         // Async reset, high
  input  wire logic          force_reset, // Hold in test logic reset
  input  wire logic          tms,         // Mode select
  output mtap_pkg::mtap_state_t state,    // Current state
  output mtap_pkg::mtap_state_t state_nxt // State after next edge
);
  mtap_pkg::mtap_state_t walk;

  always_comb begin
    case (state)
      mtap_pkg::ST_TLR:    walk = tms ? mtap_pkg::ST_TLR : mtap_pkg::ST_RTI;
      mtap_pkg::ST_RTI:    walk = tms ? mtap_pkg::ST_SEL_DR : mtap_pkg::ST_RTI;
      mtap_pkg::ST_SEL_DR: walk = tms ? mtap_pkg::ST_SEL_IR : mtap_pkg::ST_CAP_DR;
      mtap_pkg::ST_CAP_DR: walk = tms ? mtap_pkg::ST_EX1_DR : mtap_pkg::ST_SH_DR;
      mtap_pkg::ST_SH_DR:  walk = tms ? mtap_pkg::ST_EX1_DR : mtap_pkg::ST_SH_DR;
      mtap_pkg::ST_EX1_DR: walk = tms ? mtap_pkg::ST_UPD_DR : mtap_pkg::ST_PAU_DR;
      mtap_pkg::ST_PAU_DR: walk = tms ? mtap_pkg::ST_EX2_DR : mtap_pkg::ST_PAU_DR;
      mtap_pkg::ST_EX2_DR: walk = tms ? mtap_pkg::ST_UPD_DR : mtap_pkg::ST_SH_DR;
      mtap_pkg::ST_UPD_DR: walk = tms ? mtap_pkg::ST_SEL_DR : mtap_pkg::ST_RTI;
      mtap_pkg::ST_SEL_IR: walk = tms ? mtap_pkg::ST_TLR : mtap_pkg::ST_CAP_IR;
      mtap_pkg::ST_CAP_IR: walk = tms ? mtap_pkg::ST_EX1_IR : mtap_pkg::ST_SH_IR;
      mtap_pkg::ST_SH_IR:  walk = tms ? mtap_pkg::ST_EX1_IR : mtap_pkg::ST_SH_IR;
      mtap_pkg::ST_EX1_IR: walk = tms ? mtap_pkg::ST_UPD_IR : mtap_pkg::ST_PAU_IR;
      mtap_pkg::ST_PAU_IR: walk = tms ? mtap_pkg::ST_EX2_IR : mtap_pkg::ST_PAU_IR;
      mtap_pkg::ST_EX2_IR: walk = tms ? mtap_pkg::ST_UPD_IR : mtap_pkg::ST_SH_IR;
      mtap_pkg::ST_UPD_IR: walk = tms ? mtap_pkg::ST_SEL_DR : mtap_pkg::ST_RTI;
      default:             walk = mtap_pkg::ST_TLR;
    endcase
  end

  // TMS sampled on the rising edge picks the next state unless force_reset holds it in test logic reset
  assign state_nxt = force_reset ? mtap_pkg::ST_TLR : walk; // RULE1 RULE14

  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      state <= mtap_pkg::ST_TLR;
    end else begin
      state <= state_nxt; // RULE15
    end
  end
endmodule
`default_nettype wire

// File: core/mtap_sync.sv
`timescale 1ns/100ps
`default_nettype none
module mtap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,  // Destination clock
  input  wire logic         rst,  // Async reset, high
  input  wire logic [W-1:0] d,    // Asynchronous input
  output logic      [W-1:0] q     // Synchronised output
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: core/mtap_top.sv
// Functional notes
// RULE1 - TMS at rising TCK alone picks next state; a software reset request here also forces test logic reset
// RULE2 - Code 000 captures ring, drivers stay on
// RULE3 - Code 001 loads and selects identification word
// RULE4 - Code 010 captures ring, drivers forced off
// RULE5 - Controller never loads codes 011, 101, 110; here they still load and select the bypass register
// RULE6 - Code 100 captures ring, shifted data unused
// RULE7 - Code 111 selects one-bit bypass register
// RULE8 - ID fields: revision, device type, vendor
// RULE9 - ID bit 0 always reads one
// RULE10 - Boundary chain is 107 cells long
// RULE11 - Reset loads the identification-read instruction
// RULE12 - Instruction capture loads 01 into low bits
// RULE13 - TDO from LSB, changes on falling TCK
// RULE14 - Five TMS-high edges reset the controller
// RULE15 - Sixteen-state controller; instruction applied on update
// RULE16 - Data capture, shift, hold in pause/exit
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module mtap_top #(
  parameter logic [2:0]  ID_REV = mtap_pkg::ID_REV_DEF, // Revision
  parameter logic [16:0] ID_DEV = mtap_pkg::ID_DEV_DEF, // Device type
  parameter logic [10:0] ID_VEN = mtap_pkg::ID_VEN_DEF  // Vendor
) (
  input  wire logic                        clk,           // Bus clock
  input  wire logic                        rst,           // Async reset
  input  wire logic [mtap_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write addr
  input  wire logic                        s_axi_awvalid, // Write addr valid
  output logic                             s_axi_awready, // Write addr ready
  input  wire logic [31:0]                 s_axi_wdata,   // Write data
  input  wire logic [3:0]                  s_axi_wstrb,   // Byte enables
  input  wire logic                        s_axi_wvalid,  // Write data valid
  output logic                             s_axi_wready,  // Write data ready
  output logic [1:0]                       s_axi_bresp,   // Write response
  output logic                             s_axi_bvalid,  // Response valid
  input  wire logic                        s_axi_bready,  // Response ready
  input  wire logic [mtap_pkg::ADDR_W-1:0] s_axi_araddr,  // Read addr
  input  wire logic                        s_axi_arvalid, // Read addr valid
  output logic                             s_axi_arready, // Read addr ready
  output logic [31:0]                      s_axi_rdata,   // Read data
  output logic [1:0]                       s_axi_rresp,   // Read response
  output logic                             s_axi_rvalid,  // Read data valid
  input  wire logic                        s_axi_rready,  // Read data ready
  input  wire logic                        tck,           // Test clock
  input  wire logic                        tms,           // Mode select
  input  wire logic                        tdi,           // Serial in
  output logic                             tdo,           // Serial out
  output logic                             tdo_oe,        // TDO driven
  input  wire logic [mtap_pkg::BSR_W-1:0]  ring_in,       // I/O ring pins
  output logic                             out_hiz        // Drivers off
);

  localparam logic [mtap_pkg::ID_W-1:0] ID_WORD = {
    ID_REV, ID_DEV, ID_VEN, 1'b1}; // RULE8 RULE9

  function automatic logic sel_ring(input logic [2:0] code);
    sel_ring = (code == mtap_pkg::INS_RING_CAPTURE) ||
               (code == mtap_pkg::INS_RING_HIZ) ||
               (code == mtap_pkg::INS_RING_SAMPLE);
  endfunction

  function automatic logic sel_id(input logic [2:0] code);
    sel_id = (code == mtap_pkg::INS_ID_READ);
  endfunction

  // ---------------- Test clock domain ----------------

  mtap_pkg::mtap_state_t         state;
  mtap_pkg::mtap_state_t         state_nxt;
  logic                          trst_s;
  logic [mtap_pkg::BSR_W-1:0]    ring_s;
  logic [mtap_pkg::IR_W-1:0]     ir_r;
  logic [mtap_pkg::IR_W-1:0]     ir_sh_r;
  logic                          hiz_r;
  logic                          stat_tog_r;
  logic                          byp_r;
  logic [mtap_pkg::ID_W-1:0]     id_sh_r;
  logic [mtap_pkg::BSR_W-1:0]    bsr_r;
  logic                          ctrl_trst_r;

  mtap_sync #(
    .W (1)
  ) u_trst_sync (
    .clk (tck),
    .rst (rst),
    .d   (ctrl_trst_r),
    .q   (trst_s)
  );

  // Pin snapshot may be caught mid-transition; only metastability is fenced
  mtap_sync #(
    .W (mtap_pkg::BSR_W)
  ) u_ring_sync (
    .clk (tck),
    .rst (rst),
    .d   (ring_in),
    .q   (ring_s)
  );

  // Controller; a software request pins it in reset
  mtap_fsm u_fsm (
    .tck         (tck),
    .rst         (rst),
    .force_reset (trst_s),
    .tms         (tms),
    .state       (state),
    .state_nxt   (state_nxt)
  );

  // State decodes for the scan registers
  wire st_tlr    = (state == mtap_pkg::ST_TLR);
  wire st_cap_ir = (state == mtap_pkg::ST_CAP_IR);
  wire st_sh_ir  = (state == mtap_pkg::ST_SH_IR);
  wire st_cap_dr = (state == mtap_pkg::ST_CAP_DR);
  wire st_sh_dr  = (state == mtap_pkg::ST_SH_DR);
  wire to_upd_ir = (state_nxt == mtap_pkg::ST_UPD_IR);

  // Data register picked by the active instruction
  wire dr_ring = sel_ring(ir_r);
  wire dr_id   = sel_id(ir_r);
  wire dr_byp  = !dr_ring && !dr_id;

  wire [mtap_pkg::IR_W-1:0] ir_new = st_tlr ? mtap_pkg::INS_ID_READ
                                            : ir_sh_r;
  wire ir_load = st_tlr || to_upd_ir;
  wire ir_chg  = ir_load && (ir_new != ir_r);

  wire dr_lsb = dr_ring ? bsr_r[0] :
                dr_id   ? id_sh_r[0] : byp_r;

  // Instruction shift register
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir_sh_r <= mtap_pkg::INS_ID_READ;
    end else if (st_cap_ir) begin
      ir_sh_r <= {1'b0, mtap_pkg::IR_CAPTURE_PAT}; // RULE12
    end else if (st_sh_ir) begin
      ir_sh_r <= {tdi, ir_sh_r[mtap_pkg::IR_W-1:1]};
    end
  end

  // Active instruction; changes only on reset or entering update
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      ir_r       <= mtap_pkg::INS_ID_READ; // RULE11
      hiz_r      <= 1'b0;
      stat_tog_r <= 1'b0;
    end else if (ir_chg) begin
      ir_r       <= ir_new; // RULE11 RULE15
      hiz_r      <= (ir_new == mtap_pkg::INS_RING_HIZ); // RULE4 RULE2
      stat_tog_r <= ~stat_tog_r;
    end
  end

  assign out_hiz = hiz_r; // RULE4

  // Bypass cell; unknown codes also land here
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      byp_r <= 1'b0;
    end else if (dr_byp && st_cap_dr) begin
      byp_r <= 1'b0; // RULE7 RULE5
    end else if (dr_byp && st_sh_dr) begin
      byp_r <= tdi; // RULE7 RULE16
    end
  end

  // Identification word shifter
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      id_sh_r <= '0;
    end else if (dr_id && st_cap_dr) begin
      id_sh_r <= ID_WORD; // RULE3
    end else if (dr_id && st_sh_dr) begin
      id_sh_r <= {tdi, id_sh_r[mtap_pkg::ID_W-1:1]}; // RULE16
    end
  end

  // Boundary chain; contents never drive pins
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      bsr_r <= '0;
    end else if (dr_ring && st_cap_dr) begin
      bsr_r <= ring_s; // RULE2 RULE4 RULE6
    end else if (dr_ring && st_sh_dr) begin
      bsr_r <= {tdi, bsr_r[mtap_pkg::BSR_W-1:1]}; // RULE10 RULE16 RULE6
    end
  end

  // Serial out on the falling edge, driven only while shifting
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= st_sh_ir ? ir_sh_r[0] : (st_sh_dr && dr_lsb); // RULE13
      tdo_oe <= st_sh_ir || st_sh_dr; // RULE13
    end
  end

  // ---------------- Bus clock domain ----------------

  logic                        tog_s;
  logic                        tog_d_r;
  logic [mtap_pkg::IR_W-1:0]   stat_ir_r;
  logic                        stat_hiz_r;

  mtap_sync #(
    .W (1)
  ) u_tog_sync (
    .clk (clk),
    .rst (rst),
    .d   (stat_tog_r),
    .q   (tog_s)
  );

  wire stat_take = tog_s ^ tog_d_r;

  // Instruction word is held stable long before the toggle arrives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_d_r    <= 1'b0;
      stat_ir_r  <= mtap_pkg::INS_ID_READ;
      stat_hiz_r <= 1'b0;
    end else begin
      tog_d_r <= tog_s;
      if (stat_take) begin
        stat_ir_r  <= ir_r;
        stat_hiz_r <= hiz_r;
      end
    end
  end

  logic                        aw_held_r;
  logic [mtap_pkg::ADDR_W-1:0] aw_addr_r;
  logic                        w_held_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;

  // Write channel handshakes
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire b_done  = s_axi_bvalid && s_axi_bready;
  wire wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;

  wire wr_word   = (aw_addr_r[1:0] == 2'h0);
  wire wr_ctrl   = wr_word && (aw_addr_r == mtap_pkg::ADDR_CTRL);
  wire wr_ro     = wr_word && ((aw_addr_r == mtap_pkg::ADDR_STATUS) ||
                               (aw_addr_r == mtap_pkg::ADDR_IDCODE));
  wire wr_mapped = wr_ctrl || wr_ro;

  // Write address and data taken in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= '0;
      s_axi_awready <= 1'b0;
    end else if (aw_take) begin
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (b_done || (!aw_held_r && !s_axi_bvalid)) begin
      aw_held_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held_r     <= 1'b0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
      s_axi_wready <= 1'b0;
    end else if (w_take) begin
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (b_done || (!w_held_r && !s_axi_bvalid)) begin
      w_held_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Response once address and data are both held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mtap_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? mtap_pkg::RESP_OKAY
                                : mtap_pkg::RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-held test logic reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_trst_r <= mtap_pkg::CTRL_RST;
    end else if (wr_go && wr_ctrl && w_strb_r[0]) begin
      ctrl_trst_r <= w_data_r[mtap_pkg::CTRL_TRST_BIT];
    end
  end

  // Read channel; unmapped or unaligned reads give zero
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done  = s_axi_rvalid && s_axi_rready;

  wire        rd_word = (s_axi_araddr[1:0] == 2'h0);
  wire        rd_ctrl = rd_word && (s_axi_araddr == mtap_pkg::ADDR_CTRL);
  wire        rd_stat = rd_word && (s_axi_araddr == mtap_pkg::ADDR_STATUS);
  wire        rd_id   = rd_word && (s_axi_araddr == mtap_pkg::ADDR_IDCODE);
  wire [31:0] ctrl_word = {31'h0, ctrl_trst_r};
  wire [31:0] stat_word = {28'h0, stat_hiz_r, stat_ir_r};
  wire [31:0] rd_mux = rd_ctrl ? ctrl_word :
                       rd_stat ? stat_word :
                       rd_id   ? ID_WORD : 32'h0;

  // Address ready returns with the read handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= mtap_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (rd_ctrl || rd_stat || rd_id) ? mtap_pkg::RESP_OKAY
                                                     : mtap_pkg::RESP_SLVERR;
    end else if (r_done || !s_axi_rvalid) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: shared/mtap_pkg.sv
`default_nettype none
package mtap_pkg;

  // Scan register lengths
  localparam int IR_W  = 3;
  localparam int ID_W  = 32;
  localparam int BSR_W = 107;

  // Instruction codes
  localparam logic [2:0] INS_RING_CAPTURE = 3'h0;
  localparam logic [2:0] INS_ID_READ      = 3'h1;
  localparam logic [2:0] INS_RING_HIZ     = 3'h2;
  localparam logic [2:0] INS_RING_SAMPLE  = 3'h4;
  localparam logic [2:0] INS_BYPASS       = 3'h7;

  // Pattern loaded into the two low bits on instruction capture
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

  // Identification word layout
  localparam int ID_REV_LSB     = 29;
  localparam int ID_DEV_LSB     = 12;
  localparam int ID_VEN_LSB     = 1;
  localparam int ID_PRESENT_BIT = 0;
  localparam logic [2:0]  ID_REV_DEF = 3'h0;
  // Arbitrary values
  localparam logic [16:0] ID_DEV_DEF = 17'h0A5A5;
  localparam logic [10:0] ID_VEN_DEF = 11'h2AA;

  // Register map, byte addresses
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_IDCODE = 8'h08;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic        CTRL_RST    = 1'h0;
  localparam int          CTRL_TRST_BIT = 0;
  localparam int          STAT_IR_LSB   = 0;
  localparam int          STAT_HIZ_BIT  = 3;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } mtap_state_t;

endpackage
`default_nettype wire

// File: tb/mtap_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module mtap_ctl_model (
  output logic      tck,     // Test clock
  output logic      tms,     // Mode select
  output logic      tdi,     // Serial data in
  input  wire logic tdo_line // Resolved serial out
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 48 ns cycle; clock stands low between calls
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #12;
    o = tdo_line;
    tck = 1'b1;
    #24;
    tck = 1'b0;
    #12;
  endtask
  task automatic walk(input logic [15:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) tick(m[i], 1'b0, o);
  endtask
  // Last bit leaves shift with tms high
  task automatic scan(input int n, input logic [255:0] din,
                      output logic [255:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/mtap_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module mtap_chk (
  input wire logic        clk,           // Bus clock
  input wire logic        rst,           // Reset
  input wire logic        s_axi_awvalid, // Write addr valid
  input wire logic        s_axi_awready, // Write addr ready
  input wire logic        s_axi_wvalid,  // Write data valid
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic [1:0]  s_axi_bresp,   // Write response
  input wire logic        s_axi_bvalid,  // Response valid
  input wire logic        s_axi_bready,  // Response ready
  input wire logic        s_axi_arvalid, // Read addr valid
  input wire logic        s_axi_arready, // Read addr ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        s_axi_rvalid,  // Read valid
  input wire logic        s_axi_rready,  // Read ready
  input wire logic        tck,           // Test clock
  input wire logic        tms,           // Mode select
  input wire logic        tdo,           // Serial out
  input wire logic        tdo_oe,        // Serial out driven
  input wire logic        out_hiz        // Drivers off
);
  logic tdo_rise_r;
  always_ff @(posedge tck or posedge rst) begin
    if (rst)
      tdo_rise_r <= 1'b0;
    else
      tdo_rise_r <= tdo;
  end
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence tms_five;
    tms [*5];
  endsequence
  chk_b_follow_taken: assert property (@(posedge clk) disable iff (rst)
    aw_w_taken |-> ##2 s_axi_bvalid) else $error("bvalid missing");
  chk_b_holds_resp: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_b_blocks_ready: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  chk_r_follow_taken: assert property (@(posedge clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("rvalid missing");
  chk_r_holds_data: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_tdo_idle_low: assert property (@(posedge tck) disable iff (rst)
    !tdo_oe |-> !tdo) else $error("tdo high while not driven");
  chk_tdo_fall_only: assert property (@(negedge tck) disable iff (rst)
    tdo == tdo_rise_r) else $error("tdo moved in high phase");
  chk_tap_five_reset: assert property (@(posedge tck) disable iff (rst)
    tms_five |=> !tdo_oe ##1 !out_hiz) else $error("no tap reset");
  chk_hiz_on_update: assert property (@(posedge tck) disable iff (rst)
    $rose(out_hiz) |-> $past(tms)) else $error("hiz off update");
endmodule
bind mtap_top mtap_chk u_chk (.*);
`default_nettype wire

// File: tb/tb_mtap_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mtap_top;
  logic         clk, rst, tdo, tdo_oe, out_hiz, hiz_exp;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rr;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready;
  logic [106:0] ring_in;
  logic [255:0] sa, sb;
  logic         tdo_q = 1'b0;
  wire          tck, tms, tdi, tdo_line;
  int           mismatches, checks, cycles;
  localparam logic [31:0] ID_WORD = {mtap_pkg::ID_REV_DEF,
    mtap_pkg::ID_DEV_DEF, mtap_pkg::ID_VEN_DEF, 1'b1};
  // Released line toggles instead of holding
  assign tdo_line = tdo_oe ? tdo : ~tdo_q;
  always @(posedge clk) tdo_q <= tdo_line;
  mtap_top DUT (.*);
  mtap_ctl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_line(tdo_line));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("Error %0t: timeout", $time);
      stop_test();
    end
  end
  task automatic stop_test();
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    cmp(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    repeat (4) @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    cmp({s_axi_rresp, s_axi_rdata}, {er, ed});
    s_axi_rready <= 1'b0;
  endtask
  task automatic dr_scan(input int n, input logic [255:0] din,
                         output logic [255:0] dout);
    ctl.walk(16'h0001, 3);
    ctl.scan(n, din, dout);
    ctl.walk(16'h0001, 2);
  endtask
  task automatic ir_load(input logic [2:0] code);
    ctl.walk(16'h0003, 4);
    ctl.scan(3, code, sa);
    cmp(sa, 256'h1);
    cmp(out_hiz, hiz_exp);
    ctl.walk(16'h0001, 2);
    hiz_exp = (code == 3'h2);
    cmp(out_hiz, hiz_exp);
  endtask
  task automatic t_bus_regs();
    rd_chk(mtap_pkg::ADDR_STATUS, 32'h1, mtap_pkg::RESP_OKAY);
    rd_chk(mtap_pkg::ADDR_IDCODE, ID_WORD, mtap_pkg::RESP_OKAY);
    wr_chk(mtap_pkg::ADDR_STATUS, 32'hFFFFFFFF, 4'hF, mtap_pkg::RESP_OKAY);
    rd_chk(mtap_pkg::ADDR_STATUS, 32'h1, mtap_pkg::RESP_OKAY);
    wr_chk(8'h0C, 32'h1, 4'hF, mtap_pkg::RESP_SLVERR);
    rd_chk(8'h0C, 32'h0, mtap_pkg::RESP_SLVERR);
    rd_chk(8'h02, 32'h0, mtap_pkg::RESP_SLVERR);
  endtask
  task automatic t_id_pause();
    ctl.walk(16'h0001, 3);
    ctl.scan(10, '0, sa);
    ctl.walk(16'h0004, 4);
    ctl.scan(22, '0, sb);
    ctl.walk(16'h0001, 2);
    cmp({sb[21:0], sa[9:0]}, ID_WORD);
  endtask
  task automatic t_codes();
    logic [2:0] c;
    logic [255:0] din;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      if (c == 3'h3 || c == 3'h5 || c == 3'h6) continue;
      din = {4{64'h0F1E2D3C4B5A6978}};
      @(posedge clk);
      ring_in <= {ring_in[105:0], ring_in[106]};
      ir_load(c);
      if (c == 3'h0 || c == 3'h2 || c == 3'h4) begin
        dr_scan(214, din, sa);
        cmp(sa, {din[106:0], ring_in});
      end else if (c == 3'h1) begin
        dr_scan(32, din, sa);
        cmp(sa, ID_WORD);
      end else begin
        dr_scan(8, din, sa);
        cmp(sa, {din[6:0], 1'b0});
      end
      rd_chk(mtap_pkg::ADDR_STATUS, {28'h0, hiz_exp, c}, 2'h0);
    end
  endtask
  task automatic t_tap_reset();
    ir_load(3'h2);
    ctl.walk(16'h001F, 6);
    hiz_exp = 1'b0;
    cmp(out_hiz, 1'b0);
    rd_chk(mtap_pkg::ADDR_STATUS, 32'h1, mtap_pkg::RESP_OKAY);
    dr_scan(32, '0, sa);
    cmp(sa, ID_WORD);
  endtask
  task automatic t_force();
    ir_load(3'h2);
    wr_chk(mtap_pkg::ADDR_CTRL, 32'h1, 4'hF, mtap_pkg::RESP_OKAY);
    ctl.walk(16'h0000, 4);
    hiz_exp = 1'b0;
    cmp(out_hiz, 1'b0);
    rd_chk(mtap_pkg::ADDR_STATUS, 32'h1, mtap_pkg::RESP_OKAY);
    wr_chk(mtap_pkg::ADDR_CTRL, 32'h0, 4'h0, mtap_pkg::RESP_OKAY);
    rd_chk(mtap_pkg::ADDR_CTRL, 32'h1, mtap_pkg::RESP_OKAY);
    wr_chk(mtap_pkg::ADDR_CTRL, 32'h0, 4'hF, mtap_pkg::RESP_OKAY);
    rd_chk(mtap_pkg::ADDR_CTRL, 32'h0, mtap_pkg::RESP_OKAY);
    ctl.walk(16'h0000, 1);
  endtask
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    ring_in = 107'h5123456789ABCDEF013579BDF;
    hiz_exp = 1'b0;
    ctl.walk(16'h001F, 5);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_bus_regs();
    ctl.walk(16'h0000, 1);
    t_id_pause();
    t_codes();
    t_tap_reset();
    t_force();
    stop_test();
  end
endmodule
`default_nettype wire
